// File: hdl/asfc_top.sv
// Serial unit top: APB registers, clock source and pin control
// Notes on behaviour
// - Async, both clock bits 0: internal, pin unused
// - Async, clk_src_lo only: drive bit rate clock
// - Async, clk_src_hi: pin gives 16x clock
// - Sync, clk_src_hi 0: internal, clock driven out
// - Sync, clk_src_hi 1: clock taken from pin
// - Each character framed by start and stop
// - Transmit and receive run independently
// - Both directions double buffered, back to back
// - Line idles high, low starts a frame
// - Start, data lsb first, extra bit, stop
// - Sample each bit on eighth 16x tick
// - seven_bit_select picks seven or eight bits
// - extra_end_bit selects one or two stops
// - Clock out rises at transmit bit centre
// - Received parity checked against odd_even_select
// - Only first stop bit checked on receive
//
// The placing of the registers and the APB register port were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "asfc_cfg.svh"
module asfc_top
    import asfc_pkg::*;
(
    // Clock and reset
    input  wire logic        i_sys_clk,
    input  wire logic        i_rst,
    // APB slave
    input  wire logic        i_psel,
    input  wire logic        i_penable,
    input  wire logic        i_pwrite,
    input  wire logic [7:0]  i_paddr,
    input  wire logic [31:0] i_pwdata,
    output logic             o_prdata_dummy_unused,
    output logic [31:0]      o_prdata,
    output logic             o_pready,
    output logic             o_pslverr,
    // Serial lines
    input  wire logic        i_rxd,
    output logic             o_txd,
    // Serial clock pin
    input  wire logic        i_sck,
    output logic             o_sck,
    output logic             o_sck_oe
);
    typedef struct packed {
        logic [5:0]  fmt;
        logic [4:0]  ctl;
        logic [15:0] baud;
        logic [15:0] div;
        logic        tick;
        logic [7:0]  tdr;
        logic        tdr_full;
        logic [7:0]  rdr;
        logic        rdr_full;
        logic        tend;
        logic        perr;
        logic        ferr;
        logic        orer;
        logic        rxwake;
        logic        rxd_s1;
        logic        rxd_s2;
        logic        sck_s1;
        logic        sck_s2;
        logic        sck_prev;
        logic        sck_out;
        logic        sck_oe;
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } asfc_top_t;

    asfc_top_t   r_reg;
    asfc_top_t   r_next;
    logic        access;
    logic        wr_tx;
    logic        tx_take;
    logic        tx_txd;
    logic        tx_phase;
    logic        tx_idle;
    logic        rx_done;
    logic [7:0]  rx_data;
    logic        rx_xbit;
    logic        rx_perr;
    logic        rx_ferr;
    logic        ext_clk;
    logic        rx_en;
    logic [31:0] status;

    assign ext_clk = r_reg.ctl[`ASFC_CTL_CKHI];
    // Receiving stalls until software clears a receive error
    assign rx_en = r_reg.ctl[`ASFC_CTL_RXEN] && !(r_reg.perr || r_reg.ferr || r_reg.orer);
    assign access = i_psel && i_penable && !r_reg.pready;
    assign wr_tx = access && i_pwrite && (i_paddr == `ASFC_OFF_TXDATA);
    assign status = {25'h000_0000, r_reg.rxwake, r_reg.orer, r_reg.ferr, r_reg.perr,
                     r_reg.tend, r_reg.rdr_full, !r_reg.tdr_full};

    asfc_tx u_tx (
        .i_sys_clk (i_sys_clk),
        .i_rst     (i_rst),
        .i_tick    (r_reg.tick),
        .i_seven   (r_reg.fmt[`ASFC_FMT_SEVEN]),
        .i_par_en  (r_reg.fmt[`ASFC_FMT_PAR_EN]),
        .i_odd     (r_reg.fmt[`ASFC_FMT_ODD]),
        .i_mp      (r_reg.fmt[`ASFC_FMT_MP]),
        .i_stop2   (r_reg.fmt[`ASFC_FMT_STOP2]),
        .i_wake    (r_reg.ctl[`ASFC_CTL_WAKE]),
        .i_valid   (r_reg.tdr_full && r_reg.ctl[`ASFC_CTL_TXEN]),
        .i_data    (r_reg.tdr),
        .o_take    (tx_take),
        .o_txd     (tx_txd),
        .o_phase   (tx_phase),
        .o_idle    (tx_idle)
    );

    asfc_rx u_rx (
        .i_sys_clk (i_sys_clk),
        .i_rst     (i_rst),
        .i_tick    (r_reg.tick),
        .i_rxd     (r_reg.rxd_s2),
        .i_en      (rx_en),
        .i_seven   (r_reg.fmt[`ASFC_FMT_SEVEN]),
        .i_par_en  (r_reg.fmt[`ASFC_FMT_PAR_EN]),
        .i_odd     (r_reg.fmt[`ASFC_FMT_ODD]),
        .i_mp      (r_reg.fmt[`ASFC_FMT_MP]),
        .o_done    (rx_done),
        .o_data    (rx_data),
        .o_xbit    (rx_xbit),
        .o_perr    (rx_perr),
        .o_ferr    (rx_ferr)
    );

    always_comb
    begin
        r_next = r_reg;
        r_next.pready = 1'b0;
        r_next.pslverr = 1'b0;
        // Two flops on each pin before any use
        r_next.rxd_s1 = i_rxd;
        r_next.rxd_s2 = r_reg.rxd_s1;
        r_next.sck_s1 = i_sck;
        r_next.sck_s2 = r_reg.sck_s1;
        r_next.sck_prev = r_reg.sck_s2;
        r_next.tick = 1'b0;
        if (ext_clk)
        begin
            // Pin rising edges serve as the 16x tick
            r_next.tick = r_reg.sck_s2 && !r_reg.sck_prev;
            r_next.div = 16'h0000;
        end
        else if (r_reg.div >= r_reg.baud)
        begin
            r_next.tick = 1'b1;
            r_next.div = 16'h0000;
        end
        else
            r_next.div = r_reg.div + 16'h0001;
        // Pin driven only where the mode asks for it
        // Clock out in sync mode or with clock bit lo, unless pin is source
        r_next.sck_oe = !ext_clk
                        && (r_reg.fmt[`ASFC_FMT_SYNC] || r_reg.ctl[`ASFC_CTL_CKLO]);
        // Upper half of the bit phase puts the rise mid bit
        r_next.sck_out = tx_phase;
        r_next.tend = tx_idle && !r_reg.tdr_full;
        // Holding register freed as the shifter takes it
        if (tx_take)
            r_next.tdr_full = 1'b0;
        if (access)
        begin
            r_next.pready = 1'b1;
            r_next.prdata = 32'h0000_0000;
            case (i_paddr)
                `ASFC_OFF_FORMAT:
                begin
                    r_next.prdata = {26'h000_0000, r_reg.fmt};
                    if (i_pwrite)
                        r_next.fmt = i_pwdata[5:0];
                end
                `ASFC_OFF_CONTROL:
                begin
                    r_next.prdata = {27'h000_0000, r_reg.ctl};
                    if (i_pwrite)
                        r_next.ctl = i_pwdata[4:0];
                end
                `ASFC_OFF_BAUD:
                begin
                    r_next.prdata = {16'h0000, r_reg.baud};
                    if (i_pwrite)
                        r_next.baud = i_pwdata[15:0];
                end
                `ASFC_OFF_TXDATA:
                begin
                    r_next.prdata = {24'h00_0000, r_reg.tdr};
                    if (i_pwrite)
                    begin
                        r_next.tdr = i_pwdata[7:0];
                        r_next.tdr_full = 1'b1;
                    end
                end
                `ASFC_OFF_RXDATA:
                begin
                    r_next.prdata = {24'h00_0000, r_reg.rdr};
                    if (!i_pwrite)
                        r_next.rdr_full = 1'b0;
                end
                `ASFC_OFF_STATUS:
                begin
                    r_next.prdata = status;
                    // Write one to clear
                    if (i_pwrite)
                    begin
                        r_next.rdr_full = r_reg.rdr_full && !i_pwdata[`ASFC_ST_RDRF];
                        r_next.perr = r_reg.perr && !i_pwdata[`ASFC_ST_PERR];
                        r_next.ferr = r_reg.ferr && !i_pwdata[`ASFC_ST_FERR];
                        r_next.orer = r_reg.orer && !i_pwdata[`ASFC_ST_ORER];
                    end
                end
                default:
                    r_next.pslverr = 1'b1;
            endcase
        end
        // Completed character moves to the read buffer unless it was full, then overrun is set; a same-cycle read still clears full
        if (rx_done)
        begin
            if (r_reg.rdr_full)
                r_next.orer = 1'b1;
            else
            begin
                r_next.rdr = rx_data;
                r_next.rxwake = rx_xbit;
                r_next.perr = r_reg.perr || rx_perr;
                r_next.ferr = r_reg.ferr || rx_ferr;
                r_next.rdr_full = !(rx_perr || rx_ferr);
            end
        end
    end

    always_ff @(posedge i_sys_clk)
    begin
        if (i_rst)
            r_reg <= '{fmt: `ASFC_FMT_RESET, ctl: `ASFC_CTL_RESET, baud: `ASFC_BAUD_RESET,
                       rxd_s1: 1'b1, rxd_s2: 1'b1, default: '0};
        else
            r_reg <= r_next;
    end

    // Tx line is already a flop inside the shifter
    assign o_txd = tx_txd;
    assign o_sck = r_reg.sck_out;
    assign o_sck_oe = r_reg.sck_oe;
    assign o_prdata = r_reg.prdata;
    assign o_pready = r_reg.pready;
    assign o_pslverr = r_reg.pslverr;
    assign o_prdata_dummy_unused = 1'b0;

    // Checks on bus, clock source, transmit and receive buffers
    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (i_rst);
    chk_pin_unused: assert property (
        !r_reg.fmt[`ASFC_FMT_SYNC] && r_reg.ctl[1:0] == 2'b00 |=> !o_sck_oe)
        else $error("clock pin driven when unused");
    chk_pin_clock_out: assert property (
        !r_reg.fmt[`ASFC_FMT_SYNC] && r_reg.ctl[1:0] == 2'b01 |=> o_sck_oe)
        else $error("bit clock not driven");
    chk_pin_ext_in: assert property (ext_clk |=> !o_sck_oe)
        else $error("pin driven in external mode");
    chk_sync_int_out: assert property (
        r_reg.fmt[`ASFC_FMT_SYNC] && !ext_clk |=> o_sck_oe)
        else $error("sync clock not driven");
    chk_ext_tick: assert property (
        ext_clk && r_reg.sck_s2 && !r_reg.sck_prev |=> r_reg.tick)
        else $error("pin edge gave no tick");
    chk_int_no_ext: assert property (
        ext_clk && !(r_reg.sck_s2 && !r_reg.sck_prev) |=> !r_reg.tick)
        else $error("tick without pin edge");
    chk_tdr_freed: assert property (tx_take && !wr_tx |=> !r_reg.tdr_full)
        else $error("holding register not freed");
    chk_rx_load: assert property (
        rx_done && !r_reg.rdr_full |=> r_reg.rdr == $past(rx_data))
        else $error("received character not stored");
    chk_sck_phase: assert property ($rose(tx_phase) |=> o_sck ##1 1)
        else $error("clock out not following bit phase");
    chk_pready_pulse: assert property (o_pready |=> !o_pready)
        else $error("pready held");
    chk_pslverr_ready: assert property (o_pslverr |-> o_pready)
        else $error("slave error without ready");
    chk_rx_overrun: assert property (rx_done && r_reg.rdr_full |=> r_reg.orer)
        else $error("overrun not flagged");
    chk_int_tick_rate: assert property (
        !ext_clk && r_reg.div >= r_reg.baud |=> r_reg.tick)
        else $error("internal tick missing");
    chk_rx_perr_set: assert property (
        rx_done && !r_reg.rdr_full && rx_perr |=> r_reg.perr)
        else $error("parity error not flagged");
endmodule : asfc_top
`default_nettype wire

// File: hdl/asfc_cfg.svh
// Register offsets, field positions and timing counts for the serial unit
`ifndef ASFC_CFG_SVH
`define ASFC_CFG_SVH
`define ASFC_OFF_FORMAT  8'h00
`define ASFC_OFF_CONTROL 8'h04
`define ASFC_OFF_BAUD    8'h08
`define ASFC_OFF_TXDATA  8'h0C
`define ASFC_OFF_RXDATA  8'h10
`define ASFC_OFF_STATUS  8'h14
`define ASFC_FMT_SEVEN   0
`define ASFC_FMT_PAR_EN  1
`define ASFC_FMT_ODD     2
`define ASFC_FMT_MP      3
`define ASFC_FMT_STOP2   4
`define ASFC_FMT_SYNC    5
`define ASFC_CTL_CKLO    0
`define ASFC_CTL_CKHI    1
`define ASFC_CTL_TXEN    2
`define ASFC_CTL_RXEN    3
`define ASFC_CTL_WAKE    4
`define ASFC_ST_TDRE     0
`define ASFC_ST_RDRF     1
`define ASFC_ST_TEND     2
`define ASFC_ST_PERR     3
`define ASFC_ST_FERR     4
`define ASFC_ST_ORER     5
`define ASFC_ST_WAKE     6
`define ASFC_FMT_RESET   6'h00
`define ASFC_CTL_RESET   5'h00
`define ASFC_BAUD_RESET  16'h0000
`define ASFC_LAST_TICK   4'hF
`define ASFC_SAMPLE_TICK 4'h7
`define ASFC_LAST_BIT8   3'h7
`define ASFC_LAST_BIT7   3'h6
`endif

// File: hdl/asfc_pkg.sv
// Types and shared helpers of the serial unit
package asfc_pkg;
    typedef enum logic [2:0] {
        ASFC_TX_IDLE  = 3'b000,
        ASFC_TX_START = 3'b001,
        ASFC_TX_DATA  = 3'b010,
        ASFC_TX_XBIT  = 3'b011,
        ASFC_TX_STOP  = 3'b100
    } asfc_tx_state_t;
    typedef enum logic [2:0] {
        ASFC_RX_IDLE  = 3'b000,
        ASFC_RX_START = 3'b001,
        ASFC_RX_DATA  = 3'b010,
        ASFC_RX_XBIT  = 3'b011,
        ASFC_RX_STOP  = 3'b100
    } asfc_rx_state_t;
    typedef struct packed {
        asfc_tx_state_t st;
        logic [3:0]     cnt;
        logic [2:0]     bitn;
        logic [7:0]     sh;
        logic           xbit;
        logic           stop_left;
        logic           txd;
        logic           take;
    } asfc_tx_t;
    typedef struct packed {
        asfc_rx_state_t st;
        logic [3:0]     cnt;
        logic [2:0]     bitn;
        logic [7:0]     sh;
        logic           xbit;
        logic           prev;
        logic           done;
        logic           perr;
        logic           ferr;
    } asfc_rx_t;
    // Parity bit that makes the ones count even, or odd
    function automatic logic asfc_parity(input logic [7:0] d, input logic seven,
                                         input logic odd);
        logic [7:0] m;
        m = seven ? {1'b0, d[6:0]} : d;
        return (^m) ^ odd;
    endfunction : asfc_parity
endpackage : asfc_pkg

// File: hdl/asfc_tx.sv
// Transmit shifter of the serial unit
`timescale 1ns/1ps
`default_nettype none
`include "asfc_cfg.svh"
module asfc_tx
    import asfc_pkg::*;
(
    // Clock and reset
    input  wire logic       i_sys_clk,
    input  wire logic       i_rst,
    // Timing and format
    input  wire logic       i_tick,
    input  wire logic       i_seven,
    input  wire logic       i_par_en,
    input  wire logic       i_odd,
    input  wire logic       i_mp,
    input  wire logic       i_stop2,
    input  wire logic       i_wake,
    // Holding register side
    input  wire logic       i_valid,
    input  wire logic [7:0] i_data,
    output logic            o_take,
    // Line side
    output logic            o_txd,
    output logic            o_phase,
    output logic            o_idle
);
    asfc_tx_t r_reg;
    asfc_tx_t r_next;
    logic     wrap;
    logic     load;

    always_comb
    begin
        r_next = r_reg;
        r_next.take = 1'b0;
        wrap = i_tick && (r_reg.cnt == `ASFC_LAST_TICK);
        load = wrap && i_valid && (r_reg.st == ASFC_TX_IDLE
               || (r_reg.st == ASFC_TX_STOP && !r_reg.stop_left));
        // Free running phase keeps the bit clock out steady even when idle
        if (i_tick)
            r_next.cnt = r_reg.cnt + 4'h1;
        if (wrap)
        begin
            case (r_reg.st)
                ASFC_TX_START:
                begin
                    r_next.st = ASFC_TX_DATA;
                    r_next.txd = r_reg.sh[0];
                    r_next.bitn = 3'h0;
                end
                ASFC_TX_DATA:
                begin
                    r_next.sh = r_reg.sh >> 1;
                    r_next.txd = r_reg.sh[1];
                    r_next.bitn = r_reg.bitn + 3'h1;
                    if (r_reg.bitn == (i_seven ? `ASFC_LAST_BIT7 : `ASFC_LAST_BIT8))
                    begin
                        r_next.st = (i_mp || i_par_en) ? ASFC_TX_XBIT : ASFC_TX_STOP;
                        r_next.txd = (i_mp || i_par_en) ? r_reg.xbit : 1'b1;
                        r_next.stop_left = i_stop2;
                    end
                end
                ASFC_TX_XBIT:
                begin
                    r_next.st = ASFC_TX_STOP;
                    r_next.txd = 1'b1;
                    r_next.stop_left = i_stop2;
                end
                ASFC_TX_STOP:
                begin
                    r_next.stop_left = 1'b0;
                    if (!r_reg.stop_left)
                        r_next.st = ASFC_TX_IDLE;
                end
                default:
                    r_next.txd = 1'b1;
            endcase
        end
        // Back to back frames from the holding register
        if (load)
        begin
            r_next.st = ASFC_TX_START;
            r_next.txd = 1'b0;
            r_next.sh = i_data;
            r_next.take = 1'b1;
            r_next.xbit = i_mp ? i_wake : asfc_parity(i_data, i_seven, i_odd);
        end
    end

    always_ff @(posedge i_sys_clk)
    begin
        if (i_rst)
            r_reg <= '{st: ASFC_TX_IDLE, txd: 1'b1, default: '0};
        else
            r_reg <= r_next;
    end

    assign o_take = r_reg.take;
    assign o_txd = r_reg.txd;
    assign o_phase = r_reg.cnt[3];
    assign o_idle = (r_reg.st == ASFC_TX_IDLE);

    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (i_rst);
    sequence s_start_bit;
        r_reg.st == ASFC_TX_START && !r_reg.txd;
    endsequence
    chk_tx_start_low: assert property (r_reg.take |-> s_start_bit)
        else $error("start bit not low");
    chk_tx_stop_high: assert property (r_reg.st == ASFC_TX_STOP |-> r_reg.txd)
        else $error("stop bit not high");
    chk_tx_idle_mark: assert property (r_reg.st == ASFC_TX_IDLE |-> r_reg.txd)
        else $error("line not idle high");
endmodule : asfc_tx
`default_nettype wire

// File: hdl/asfc_rx.sv
// Receive shifter of the serial unit
`timescale 1ns/1ps
`default_nettype none
`include "asfc_cfg.svh"
module asfc_rx
    import asfc_pkg::*;
(
    // Clock and reset
    input  wire logic       i_sys_clk,
    input  wire logic       i_rst,
    // Timing, line and format
    input  wire logic       i_tick,
    input  wire logic       i_rxd,
    input  wire logic       i_en,
    input  wire logic       i_seven,
    input  wire logic       i_par_en,
    input  wire logic       i_odd,
    input  wire logic       i_mp,
    // Result
    output logic            o_done,
    output logic [7:0]      o_data,
    output logic            o_xbit,
    output logic            o_perr,
    output logic            o_ferr
);
    asfc_rx_t   r_reg;
    asfc_rx_t   r_next;
    logic [7:0] aligned;

    always_comb
    begin
        r_next = r_reg;
        r_next.done = 1'b0;
        r_next.prev = i_rxd;
        aligned = i_seven ? {1'b0, r_reg.sh[7:1]} : r_reg.sh;
        // Falling edge from idle high starts a frame
        if (r_reg.st == ASFC_RX_IDLE)
        begin
            if (i_en && r_reg.prev && !i_rxd)
            begin
                r_next.st = ASFC_RX_START;
                r_next.cnt = 4'h0;
            end
        end
        else if (i_tick)
        begin
            r_next.cnt = r_reg.cnt + 4'h1;
            if (r_reg.cnt == `ASFC_SAMPLE_TICK)
            begin
                case (r_reg.st)
                    // Glitch shorter than half a bit is dropped
                    ASFC_RX_START:
                    begin
                        r_next.st = i_rxd ? ASFC_RX_IDLE : ASFC_RX_DATA;
                        r_next.bitn = 3'h0;
                    end
                    ASFC_RX_DATA:
                    begin
                        r_next.sh = {i_rxd, r_reg.sh[7:1]};
                        r_next.bitn = r_reg.bitn + 3'h1;
                        if (r_reg.bitn == (i_seven ? `ASFC_LAST_BIT7 : `ASFC_LAST_BIT8))
                            r_next.st = (i_mp || i_par_en) ? ASFC_RX_XBIT : ASFC_RX_STOP;
                    end
                    ASFC_RX_XBIT:
                    begin
                        r_next.xbit = i_rxd;
                        r_next.st = ASFC_RX_STOP;
                    end
                    // Only the first stop bit is checked
                    ASFC_RX_STOP:
                    begin
                        r_next.done = 1'b1;
                        r_next.sh = aligned;
                        r_next.ferr = !i_rxd;
                        // Parity check against odd or even
                        r_next.perr = !i_mp && i_par_en
                                      && (asfc_parity(aligned, i_seven, i_odd) != r_reg.xbit);
                        r_next.st = ASFC_RX_IDLE;
                    end
                    default:
                        r_next.st = ASFC_RX_IDLE;
                endcase
            end
        end
    end

    always_ff @(posedge i_sys_clk)
    begin
        if (i_rst)
            r_reg <= '{st: ASFC_RX_IDLE, prev: 1'b1, default: '0};
        else
            r_reg <= r_next;
    end

    assign o_done = r_reg.done;
    assign o_data = r_reg.sh;
    assign o_xbit = r_reg.xbit;
    assign o_perr = r_reg.perr;
    assign o_ferr = r_reg.ferr;

    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (i_rst);
    chk_rx_mid_sample: assert property (
        r_reg.st == ASFC_RX_DATA && i_tick && r_reg.cnt == `ASFC_SAMPLE_TICK
        |=> r_reg.sh[7] == $past(i_rxd))
        else $error("data bit not taken at centre");
    chk_rx_stop_check: assert property (r_reg.done |-> r_reg.ferr == !$past(i_rxd))
        else $error("stop bit check wrong");
endmodule : asfc_rx
`default_nettype wire

// File: verification/asfc_peer.sv
// Remote serial device: frame sender and receiver
`timescale 1ns/1ps
`default_nettype none
module asfc_peer (
    // Clock
    input  wire logic i_sys_clk,
    // Serial lines
    input  wire logic i_line,
    output logic      o_line
);
    initial o_line = 1'b1;
    task automatic send(input logic [15:0] f, input int n, input int bt);
        for (int i = 0; i < n; i++)
        begin
            o_line <= f[i];
            repeat (bt) @(posedge i_sys_clk);
        end
        o_line <= 1'b1;
    endtask : send
    task automatic recv(input int n, input int bt, output logic [15:0] f);
        int k;
        f = 16'hFFFF;
        for (k = 0; k < 20000 && i_line !== 1'b0; k++) @(posedge i_sys_clk);
        repeat (bt / 2) @(posedge i_sys_clk);
        // Stops at last centre, so a following start is not missed
        for (int i = 0; i < n; i++)
        begin
            f[i] = i_line;
            if (i < n - 1) repeat (bt) @(posedge i_sys_clk);
        end
    endtask : recv
endmodule : asfc_peer
`default_nettype wire

// File: verification/asfc_top_tb.sv
// Self-checking bench for the serial unit top
`timescale 1ns/1ps
`default_nettype none
`include "asfc_cfg.svh"
module asfc_top_tb;
    logic        i_sys_clk = 1'b0;
    logic        i_rst = 1'b1;
    logic        i_psel = 1'b0;
    logic        i_penable = 1'b0;
    logic        i_pwrite = 1'b0;
    logic [7:0]  i_paddr = 8'h00;
    logic [31:0] i_pwdata = 32'h0000_0000;
    logic        i_sck = 1'b0;
    logic        rxd, o_txd, o_sck, o_sck_oe, o_pready, o_pslverr, se;
    logic [31:0] o_prdata, rd;
    logic [15:0] g1, g2, ef, ef2, ef3;
    logic [5:0]  fm;
    int          n_errors = 0;
    int          num_checks = 0;
    int          nb, k;
    always #2.5 i_sys_clk = ~i_sys_clk;
    always #62.5 i_sck <= ~i_sck;
    asfc_top dut (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_psel(i_psel),
        .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
        .i_pwdata(i_pwdata), .o_prdata_dummy_unused(), .o_prdata(o_prdata),
        .o_pready(o_pready), .o_pslverr(o_pslverr), .i_rxd(rxd), .o_txd(o_txd),
        .i_sck(i_sck), .o_sck(o_sck), .o_sck_oe(o_sck_oe));
    asfc_peer peer (.i_sys_clk(i_sys_clk), .i_line(o_txd), .o_line(rxd));
    task automatic wrap_up;
        $display("Checks %0d, mismatches %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : wrap_up
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
            n_errors++;
        end
    endtask : chk
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int j;
        i_psel <= 1'b1;
        i_pwrite <= w;
        i_paddr <= a;
        i_pwdata <= d;
        @(posedge i_sys_clk);
        i_penable <= 1'b1;
        @(posedge i_sys_clk);
        for (j = 0; j < 20 && o_pready !== 1'b1; j++) @(posedge i_sys_clk);
        rd = o_prdata;
        se = o_pslverr;
        i_psel <= 1'b0;
        i_penable <= 1'b0;
        // Idle edge keeps the next setup out of this time step
        @(posedge i_sys_clk);
        if (j == 20)
        begin
            n_errors++;
            wrap_up();
        end
    endtask : apb
    function automatic logic [15:0] mkf(input logic [7:0] d, input logic [5:0] f,
                                        input logic wk, output int n);
        logic [15:0] r;
        r = 16'hFFFF;
        r[0] = 1'b0;
        n = f[0] ? 8 : 9;
        for (int i = 0; i < n - 1; i++) r[i + 1] = d[i];
        if (f[3] | f[1])
        begin
            r[n] = f[3] ? wk : (^(d & (f[0] ? 8'h7F : 8'hFF))) ^ f[2];
            n++;
        end
        n = n + (f[4] ? 2 : 1);
        return r;
    endfunction : mkf
    localparam logic [5:0] FMS [4] = '{6'h12, 6'h07, 6'h19, 6'h00};
    initial
    begin
        #200us;
        n_errors++;
        wrap_up();
    end
    initial
    begin
        repeat (6) @(posedge i_sys_clk);
        i_rst <= 1'b0;
        @(posedge i_sys_clk);
        chk(o_txd, 1'b1);
        apb(0, `ASFC_OFF_FORMAT, 0);
        chk(rd, 0);
        apb(0, 8'h40, 0);
        chk(se, 1'b1);
        apb(1, `ASFC_OFF_BAUD, 3);
        for (int i = 0; i < 8; i++)
        begin
            apb(1, `ASFC_OFF_FORMAT, {26'h000_0000, i[2], 5'h00});
            apb(1, `ASFC_OFF_CONTROL, i[1:0]);
            repeat (2) @(posedge i_sys_clk);
            chk(o_sck_oe, !i[1] & (i[2] | i[0]));
        end
        apb(1, `ASFC_OFF_CONTROL, 1);
        repeat (40) @(posedge i_sys_clk);
        se = o_sck;
        // Bit clock flips every half bit of 32 cycles
        repeat (32) @(posedge i_sys_clk);
        chk(o_sck, !se);
        $display("Test clock pin done");
        for (int j = 0; j < 4; j++)
        begin
            fm = FMS[j];
            repeat (40) @(posedge i_sys_clk);
            apb(1, `ASFC_OFF_FORMAT, fm);
            apb(1, `ASFC_OFF_CONTROL, 32'h0000_001C);
            ef = mkf(8'hA5 + 8'(j), fm, 1'b1, nb);
            ef2 = mkf(8'h3C, fm, 1'b1, nb);
            ef3 = mkf(8'hC3, fm, 1'b1, nb);
            fork
                begin
                    peer.recv(nb, 64, g1);
                    peer.recv(nb, 64, g2);
                end
                begin
                    apb(1, `ASFC_OFF_TXDATA, 8'hA5 + j);
                    for (k = 0; k < 40; k++)
                    begin
                        apb(0, `ASFC_OFF_STATUS, 0);
                        if (rd[0] === 1'b1) break;
                    end
                    if (k == 40)
                    begin
                        n_errors++;
                        wrap_up();
                    end
                    apb(1, `ASFC_OFF_TXDATA, 8'h3C);
                    peer.send(ef3, nb, 64);
                end
            join
            chk(g1, ef);
            chk(g2, ef2);
            apb(0, `ASFC_OFF_STATUS, 0);
            chk(rd & 32'h0000_001A, 32'h0000_0002);
            apb(0, `ASFC_OFF_RXDATA, 0);
            chk(rd, fm[0] ? 32'h0000_0043 : 32'h0000_00C3);
            $display("Test format %0d done", j);
        end
        ef = mkf(8'h5A, 6'h02, 1'b0, nb);
        apb(1, `ASFC_OFF_FORMAT, 6'h02);
        peer.send(ef ^ 16'h0200, nb, 64);
        apb(0, `ASFC_OFF_STATUS, 0);
        chk(rd & 32'h0000_001A, 32'h0000_0008);
        apb(1, `ASFC_OFF_STATUS, 32'h0000_003A);
        peer.send(ef ^ 16'h0400, nb, 64);
        apb(0, `ASFC_OFF_STATUS, 0);
        chk(rd & 32'h0000_001A, 32'h0000_0010);
        apb(1, `ASFC_OFF_STATUS, 32'h0000_003A);
        $display("Test errors done");
        apb(1, `ASFC_OFF_FORMAT, 0);
        apb(1, `ASFC_OFF_CONTROL, 32'h0000_000A);
        // 16 link clocks of 125 ns make one 400-cycle bit
        ef = mkf(8'h69, 6'h00, 1'b0, nb);
        peer.send(ef, nb, 400);
        apb(0, `ASFC_OFF_RXDATA, 0);
        chk(rd, 32'h0000_0069);
        $display("Test external clock done");
        wrap_up();
    end
endmodule : asfc_top_tb
`default_nettype wire
